// ===== mpr_host_pkg.sv
package mpr_host_pkg;
    // Register offsets of the controller's own APB map
    localparam logic [7:0] CMD_OFS  = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    // Command register fields
    localparam int CMD_OP_LSB    = 0;
    localparam int CMD_LOC_LSB   = 4;
    localparam int CMD_PAGE_LSB  = 8;
    localparam int CMD_FMT_LSB   = 12;
    localparam int CMD_WDATA_LSB = 16;
    // Status register fields
    localparam int STAT_BUSY      = 0;
    localparam int STAT_ON        = 1;
    localparam int STAT_REFUSED   = 2;
    localparam int STAT_RDATA_LSB = 8;
    localparam int STAT_TREF_LSB  = 16;
    localparam int STAT_PAGE_LSB  = 20;
    localparam int STAT_FMT_LSB   = 24;
    // Mode register 3 fields and select, and the refresh code position in the page 2 byte
    localparam int         MR3_EN_BIT   = 2;
    localparam int         MR3_FMT_LSB  = 11;
    localparam int         MR3_PAGE_LSB = 0;
    localparam logic [1:0] MR3_BA       = 2'h3;
    localparam int         TREF_LSB     = 3;
    // Read-out formats
    localparam logic [1:0] FMT_SERIAL   = 2'h0;
    localparam logic [1:0] FMT_PARALLEL = 2'h1;
    localparam logic [1:0] FMT_RSVD     = 2'h3;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_MOD_NS      = 30;
    localparam int T_RFC_NS      = 260;
    localparam int T_MPRR_NS     = 10;
    localparam int T_WRREC_NS    = 40;
    localparam int READ_LAT_CYC  = 11;
    localparam int UI_N          = 8;
    localparam int TMR_W         = 9;
    // Least time to whole cycles, never below one
    function automatic logic [TMR_W-1:0] cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? TMR_W'(1) : TMR_W'(c);
    endfunction : cyc
    localparam logic [TMR_W-1:0] MOD_CYC   = cyc(T_MOD_NS);
    localparam logic [TMR_W-1:0] RFC_CYC   = cyc(T_RFC_NS);
    localparam logic [TMR_W-1:0] MPRR_CYC  = cyc(T_MPRR_NS);
    localparam logic [TMR_W-1:0] WRREC_CYC = cyc(T_WRREC_NS);
    // Software operations
    typedef enum logic [2:0] {OP_NONE, OP_ENTER, OP_READ, OP_WRITE, OP_EXIT, OP_REFRESH} op_t;
    // Command pins towards the memory
    typedef struct packed {
        logic        cs_n;
        logic        act_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  bg;
        logic [1:0]  ba;
        logic [17:0] addr;
    } ddr_cmd_t;
    localparam ddr_cmd_t CMD_DES = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 2'h0, 18'h00000};
endpackage : mpr_host_pkg

// ===== mpr_host.sv
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - Pages 1-3 read only in serial format
// - Page 3 contents are not relied upon
// - No data bus inversion on store reads
// - Only MRS, RD, WR, DES, REF, RESET
// - No power-down or self refresh in mode
// - Nothing else until refresh cycle elapses
// - Single-rate refresh only in mode
// - Finish store accesses before refresh
// - Bit 7 is A7 and UI0
// - BA[1:0] selects the location
// - Recovery wait after last read, then exit
// - Chopped reads start at column 000/100
module mpr_host
    import mpr_host_pkg::*;
#(
    parameter int RL = READ_LAT_CYC  // Read latency in cycles
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Memory command pins
    output mpr_host_pkg::ddr_cmd_t dev_cmd,
    output logic                  cke,
    output logic                  dbi_en,
    // Memory read data lanes
    input  wire logic [7:0]       dq_i
);
    import mpr_host_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RL, ST_CAP} state_t;

    state_t           state;     // Sequencer state
    logic [TMR_W-1:0] tmr;       // Wait / latency / UI counter
    logic             mode_on;   // Store access mode entered
    logic [1:0]       cur_page;  // Active page
    logic [1:0]       cur_fmt;   // Active read-out format
    logic [1:0]       cur_loc;   // Location of the read in flight
    logic [7:0]       rdata;     // Last byte read from the store
    logic [1:0]       tref;      // Last refresh-need code seen
    logic             refused;   // Last request was turned down
    logic [31:0]      cmd_reg;   // Readback of the last command word

    // Decoded command word
    op_t        op;
    logic [1:0] req_loc;
    logic [1:0] req_page;
    logic [1:0] req_fmt;
    logic [7:0] req_wdata;
    assign op        = op_t'(pwdata[CMD_OP_LSB +: 3]);
    assign req_loc   = pwdata[CMD_LOC_LSB +: 2];
    assign req_page  = pwdata[CMD_PAGE_LSB +: 2];
    assign req_fmt   = pwdata[CMD_FMT_LSB +: 2];
    assign req_wdata = pwdata[CMD_WDATA_LSB +: 8];

    // APB decode; zero wait states
    logic acc;
    logic wr_cmd;
    logic legal;
    logic go;
    assign acc    = psel && penable;
    assign wr_cmd = acc && pwrite && (paddr == CMD_OFS);
    assign pready = 1'b1;
    assign pslverr = acc && (paddr != CMD_OFS) && (paddr != STAT_OFS);

    // Request screening: the device cannot flag a bad sequence itself
    always_comb begin
        legal = (state == ST_IDLE);
        unique case (op)
            OP_ENTER:   legal = legal && !mode_on && (req_fmt != FMT_RSVD)
                                && (req_page == 2'h0 || req_fmt == FMT_SERIAL);
            OP_READ:    legal = legal && mode_on
                                && !(cur_fmt == FMT_PARALLEL && req_loc != 2'h0);
            OP_WRITE:   legal = legal && mode_on && (cur_page == 2'h0);
            OP_EXIT:    legal = legal && mode_on;
            OP_REFRESH: legal = legal;
            default:    legal = 1'b0;
        endcase
    end
    assign go = wr_cmd && legal;

    // Power-down is never used and read inversion stays off
    assign cke    = 1'b1;
    assign dbi_en = 1'b0;

    // Register readback
    always_comb begin
        prdata = 32'h00000000;
        if (paddr == CMD_OFS) begin
            prdata = cmd_reg;
        end else if (paddr == STAT_OFS) begin
            prdata[STAT_BUSY]              = (state != ST_IDLE);
            prdata[STAT_ON]                = mode_on;
            prdata[STAT_REFUSED]           = refused;
            prdata[STAT_RDATA_LSB +: 8]    = rdata;
            prdata[STAT_TREF_LSB +: 2]     = tref;
            prdata[STAT_PAGE_LSB +: 2]     = cur_page;
            prdata[STAT_FMT_LSB +: 2]      = cur_fmt;
        end
    end

    // Command word store and refusal flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_reg <= 32'h00000000;
            refused <= 1'b0;
        end else if (wr_cmd) begin
            cmd_reg <= pwdata;
            refused <= !legal;
        end
    end

    // Mode tracking mirrors the MR3 enable bit; page and format are those written by enter, exit leaves them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_on  <= 1'b0;
            cur_page <= 2'h0;
            cur_fmt  <= FMT_SERIAL;
            cur_loc  <= 2'h0;
        end else if (go) begin
            if (op == OP_ENTER) begin
                mode_on  <= 1'b1;
                cur_page <= req_page;
                cur_fmt  <= req_fmt;
            end else if (op == OP_EXIT) begin
                mode_on <= 1'b0;
            end else if (op == OP_READ) begin
                cur_loc <= req_loc;
            end
        end
    end

    // Next byte while sampling: UI0 lands in bit 7
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = {rdata[6:0], dq_i[0]};
        if (cur_fmt == FMT_PARALLEL) begin
            // Whole byte sits on the lanes at UI0; lane 0 carries bit 7
            next_rdata = rdata;
            if (tmr == TMR_W'(UI_N - 1)) begin
                for (int i = 0; i < 8; i++) begin
                    next_rdata[7 - i] = dq_i[i];
                end
            end
        end
    end

    // Command sequencer; every slot without a command is a deselect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= ST_IDLE;
            tmr     <= '0;
            dev_cmd <= CMD_DES;
            rdata   <= 8'h00;
            tref    <= 2'h0;
        end else begin
            dev_cmd <= CMD_DES;
            unique case (state)
                ST_IDLE: begin
                    if (go) begin
                        dev_cmd <= '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 2'h0, req_loc, 18'h00000};
                        state   <= ST_WAIT;
                        unique case (op)
                            OP_ENTER, OP_EXIT: begin
                                // MRS to MR3, fine refresh bits left at 1x
                                dev_cmd <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0, MR3_BA,
                                    18'(({16'h0000, req_fmt} << MR3_FMT_LSB)
                                      | ({16'h0000, req_page} << MR3_PAGE_LSB)
                                      | ((op == OP_ENTER ? 18'h00001 : 18'h00000)
                                         << MR3_EN_BIT))};
                                tmr <= MOD_CYC;
                            end
                            OP_READ: begin
                                // Plain read, column 000, BA picks location
                                state <= ST_RL;
                                tmr   <= TMR_W'(RL - 1);
                            end
                            OP_WRITE: begin
                                // Store write data rides on A7..A0
                                dev_cmd <= '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0, req_loc,
                                    {10'h000, req_wdata}};
                                tmr <= WRREC_CYC;
                            end
                            default: begin
                                // Refresh, then hold off for the refresh cycle
                                dev_cmd <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 2'h0,
                                    18'h00000};
                                tmr <= RFC_CYC;
                            end
                        endcase
                    end
                end
                ST_WAIT: begin
                    if (tmr <= TMR_W'(1)) begin
                        state <= ST_IDLE;
                    end else begin
                        tmr <= tmr - TMR_W'(1);
                    end
                end
                ST_RL: begin
                    if (tmr == '0) begin
                        state <= ST_CAP;
                        tmr   <= TMR_W'(UI_N - 1);
                    end else begin
                        tmr <= tmr - TMR_W'(1);
                    end
                end
                ST_CAP: begin
                    rdata <= next_rdata;
                    if (tmr == '0) begin
                        // Recovery before anything, exit included
                        state <= ST_WAIT;
                        tmr   <= MPRR_CYC;
                        // Only page 2 location 0 feeds the code; page 3 bytes are never decoded
                        if (cur_page == 2'h2 && cur_loc == 2'h0) begin
                            tref <= next_rdata[TREF_LSB +: 2];
                        end
                    end else begin
                        tmr <= tmr - TMR_W'(1);
                    end
                end
            endcase
        end
    end

    // Helper for checks: cycles since the last command and its kind
    logic [TMR_W-1:0] gap;
    logic             last_ref;
    logic             last_mrs;
    logic [TMR_W-1:0] since_rd;
    logic             is_cmd;
    logic             is_mrs;
    logic             is_ref;
    logic             is_rd;
    logic             is_wr;
    assign is_cmd = !dev_cmd.cs_n;
    assign is_mrs = is_cmd && !dev_cmd.ras_n && !dev_cmd.cas_n && !dev_cmd.we_n;
    assign is_ref = is_cmd && !dev_cmd.ras_n && !dev_cmd.cas_n && dev_cmd.we_n;
    assign is_rd  = is_cmd && dev_cmd.ras_n && !dev_cmd.cas_n && dev_cmd.we_n;
    assign is_wr  = is_cmd && dev_cmd.ras_n && !dev_cmd.cas_n && !dev_cmd.we_n;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap      <= '1;
            last_ref <= 1'b0;
            last_mrs <= 1'b0;
            since_rd <= '1;
        end else begin
            if (is_cmd) begin
                gap      <= TMR_W'(1);
                last_ref <= is_ref;
                last_mrs <= is_mrs;
            end else if (gap != '1) begin
                gap <= gap + TMR_W'(1);
            end
            if (state == ST_CAP && tmr == '0) begin
                since_rd <= '0;
            end else if (since_rd != '1) begin
                since_rd <= since_rd + TMR_W'(1);
            end
        end
    end

    localparam int RD_MAX = 40;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rd_issue;
        is_rd && dev_cmd.addr[2:0] == 3'h0;
    endsequence
    sequence s_rd_done;
        state == ST_CAP && tmr == '0;
    endsequence

    property p_ref_gap;
        is_cmd && last_ref |-> gap >= RFC_CYC;
    endproperty
    a_ref_gap: assert property (p_ref_gap) else $error("command inside refresh cycle");
    property p_mrs_gap;
        is_cmd && last_mrs |-> gap >= MOD_CYC;
    endproperty
    a_mrs_gap: assert property (p_mrs_gap) else $error("command too soon after MRS");
    property p_legal_cmd;
        is_cmd |-> dev_cmd.act_n && (is_mrs || is_ref || is_rd || is_wr);
    endproperty
    a_legal_cmd: assert property (p_legal_cmd) else $error("illegal command issued");
    property p_no_pwrdn;
        mode_on |-> cke && !dbi_en;
    endproperty
    a_no_pwrdn: assert property (p_no_pwrdn) else $error("power-down or inversion in mode");
    property p_enter_fmt;
        is_mrs && dev_cmd.addr[MR3_EN_BIT] && dev_cmd.addr[1:0] != 2'h0
            |-> dev_cmd.addr[12:11] == FMT_SERIAL;
    endproperty
    a_enter_fmt: assert property (p_enter_fmt) else $error("non-serial format on page 1-3");
    property p_rd_col;
        is_rd |-> s_rd_issue;
    endproperty
    a_rd_col: assert property (p_rd_col) else $error("read column not 000");
    property p_rd_done;
        s_rd_issue |-> ##[1:RD_MAX] s_rd_done;
    endproperty
    a_rd_done: assert property (p_rd_done) else $error("read burst never captured");
    property p_wr_page0;
        is_wr |-> mode_on && cur_page == 2'h0;
    endproperty
    a_wr_page0: assert property (p_wr_page0) else $error("write outside page 0");
    property p_exit_rec;
        is_mrs && !dev_cmd.addr[MR3_EN_BIT] |-> since_rd > MPRR_CYC;
    endproperty
    a_exit_rec: assert property (p_exit_rec) else $error("exit before read recovery");
    property p_ref_idle;
        is_ref |-> $past(state) == ST_IDLE && state == ST_WAIT;
    endproperty
    a_ref_idle: assert property (p_ref_idle) else $error("refresh during an access");
endmodule : mpr_host

// ===== sdram_mpr_model.sv
`timescale 1ns/1ns
// Memory device seen from the controller, only in special register mode
module sdram_mpr_model
    import mpr_host_pkg::*;
#(
    parameter int RL = READ_LAT_CYC // Command to first UI
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Command pins
    input  wire mpr_host_pkg::ddr_cmd_t cmd,
    input  wire logic                   cke,
    input  wire logic                   dbi_en,
    // Data lanes and count of illegal moves seen
    output logic [7:0]                  dq,
    output logic [7:0]                  viol
);
    logic [7:0] mem [4][4]; // Four pages of four bytes
    logic       on;         // Access mode
    logic [1:0] pg;         // Active page
    logic [1:0] fmt;        // Read-out format
    logic [1:0] loc;        // Location of the running burst
    int         cnt;        // Burst timer, zero when idle
    int         rfc;        // Refresh cycle time left
    logic       tog;        // Idle pattern flip
    wire        cs  = !cmd.cs_n;
    wire        mrs = cs && cmd.act_n && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
    wire        rfr = cs && cmd.act_n && !cmd.ras_n && !cmd.cas_n && cmd.we_n;
    wire        rd  = cs && cmd.act_n && cmd.ras_n && !cmd.cas_n && cmd.we_n;
    wire        wr  = cs && cmd.act_n && cmd.ras_n && !cmd.cas_n && !cmd.we_n;
    wire        m3  = mrs && cmd.ba == MR3_BA && cmd.bg == 2'h0;

    // Decode commands, keep the store, and count moves that break the rules
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Page 0 patterns; other pages get a fixed fill per place
            for (int p = 0; p < 4; p++)
                for (int l = 0; l < 4; l++)
                    mem[p][l] <= (p == 0) ? 8'(32'h000F3355 >> (8 * l))
                               : {~2'(l), 2'(p), 2'(p), 2'(l)};
            on   <= 1'b0;
            pg   <= 2'h0;
            fmt  <= 2'h0;
            loc  <= 2'h0;
            cnt  <= 0;
            rfc  <= 0;
            tog  <= 1'b0;
            viol <= 8'h00;
        end else begin
            tog <= ~tog;
            if (m3) begin
                on  <= cmd.addr[MR3_EN_BIT];
                fmt <= cmd.addr[MR3_FMT_LSB +: 2];
                pg  <= cmd.addr[MR3_PAGE_LSB +: 2];
            end
            // Only page 0 takes writes; the rest are read-only
            if (wr && on && pg == 2'h0)
                mem[0][cmd.ba] <= cmd.addr[7:0];
            // Auto precharge bit is ignored, read acts as plain
            if (rd) begin
                loc <= cmd.ba;
                cnt <= 1;
            end else if (cnt != 0) begin
                cnt <= (cnt == RL + 7) ? 0 : cnt + 1;
            end
            rfc <= rfr ? int'(RFC_CYC) - 1 : ((rfc != 0) ? rfc - 1 : 0);
            if ((cs && rfc != 0)
                || ((mrs || rfr) && cnt != 0)
                || (on && cs && !(mrs || rd || wr || rfr))
                || ((rd || wr) && !on)
                || (rd && (cmd.addr[1:0] != 2'h0 || (pg != 2'h0 && fmt != FMT_SERIAL)))
                || (m3 && cmd.addr[MR3_FMT_LSB +: 2] == FMT_RSVD)
                || cke !== 1'b1 || dbi_en !== 1'b0)
                viol <= viol + 8'h01;
        end
    end

    // Lanes carry the burst; outside it a changing pattern, never the last bit
    always_comb begin
        dq = {4{tog, ~tog}};
        if (cnt >= RL)
            for (int i = 0; i < 8; i++)
                case (fmt)
                    FMT_PARALLEL: dq[i] = mem[pg][loc][7 - i];
                    2'h2:         dq[i] = mem[pg][loc + 2'(i)][7 - (cnt - RL)];
                    default:      dq[i] = mem[pg][loc][7 - (cnt - RL)];
                endcase
    end
endmodule : sdram_mpr_model

// ===== tb.sv
`timescale 1ns/1ns
// Bench: software orders over APB against the memory model
module tb;
    import mpr_host_pkg::*;
    localparam int LIMIT = 20000; // Whole run stays well below this
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, st;
    logic        pready, pslverr, cke, dbi_en, err;
    ddr_cmd_t    dev_cmd;
    logic [7:0]  dq, viol, b;
    int          err_count = 0;
    int          checks = 0;
    int          cyc = 0;

    always #5 pclk = ~pclk;

    mpr_host DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dev_cmd(dev_cmd), .cke(cke),
        .dbi_en(dbi_en), .dq_i(dq));
    sdram_mpr_model MEM (.clk(pclk), .rst_n(presetn), .cmd(dev_cmd), .cke(cke),
        .dbi_en(dbi_en), .dq(dq), .viol(viol));

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("Mismatches %0d, comparisons %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // One transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Order an operation, then poll busy under a bound
    task automatic op(input logic [2:0] o, input logic [1:0] l, input logic [1:0] p,
                      input logic [1:0] f, input logic [7:0] d);
        int n;
        n = 0;
        apb(1'b1, CMD_OFS, {8'h00, d, 2'b00, f, 2'b00, p, 2'b00, l, 1'b0, o});
        do begin
            apb(1'b0, STAT_OFS, 32'h0);
            n++;
        end while (rd[STAT_BUSY] !== 1'b0 && n < 100);
        // A busy flag that never drops counts as a mismatch
        if (rd[STAT_BUSY] !== 1'b0)
            err_count++;
        st = rd;
    endtask : op

    // Expected store contents
    function automatic logic [7:0] rom(input logic [1:0] p, input logic [1:0] l);
        return (p == 2'h0) ? 8'(32'h000F3355 >> (8 * l)) : {~l, p, p, l};
    endfunction : rom

    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_count++;
            end_sim;
        end
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, STAT_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk({31'h0, err}, 32'h1);
        op(OP_READ, 2'h0, 2'h0, 2'h0, 8'h00);
        chk(st[2:0], 3'b100);
        op(3'h0, 2'h0, 2'h0, 2'h0, 8'h00);
        chk(st[2:0], 3'b100);
        op(3'h6, 2'h0, 2'h0, 2'h0, 8'h00);
        chk(st[2:0], 3'b100);
        // Every format but the reserved one against every page; every location on each accepted enter
        for (int f = 0; f < 3; f++)
            for (int p = 0; p < 4; p++) begin
                op(OP_ENTER, 2'h0, 2'(p), 2'(f), 8'h00);
                if (p != 0 && f != 0) begin
                    chk(st[2:0], 3'b100);
                end else begin
                    chk({st[25:24], st[21:20], st[2:0]}, {2'(f), 2'(p), 3'b010});
                    for (int l = 0; l < 4; l++) begin
                        op(OP_READ, 2'(l), 2'h0, 2'h0, 8'h00);
                        b = rom(2'(p), 2'(l));
                        if (p == 0 && l == 1 && f != 0)
                            b = 8'hC3; // Written during the serial pass
                        if (f == 1 && l != 0)
                            chk(st[2:0], 3'b110);
                        else
                            chk({st[2:0], st[15:8]}, {3'b010, b});
                        if (p == 2 && l == 0)
                            chk(st[17:16], b[4:3]);
                    end
                    op(OP_WRITE, 2'h1, 2'h0, 2'h0, 8'hC3);
                    chk(st[2:0], (p == 0) ? 3'b010 : 3'b110);
                    op(OP_EXIT, 2'h0, 2'h0, 2'h0, 8'h00);
                    chk(st[2:0], 3'b000);
                end
            end
        // Written pattern survives refresh; second enter refused
        op(OP_ENTER, 2'h0, 2'h0, 2'h0, 8'h00);
        op(OP_WRITE, 2'h2, 2'h0, 2'h0, 8'hA6);
        op(OP_REFRESH, 2'h0, 2'h0, 2'h0, 8'h00);
        op(OP_READ, 2'h2, 2'h0, 2'h0, 8'h00);
        chk(st[15:8], 8'hA6);
        op(OP_READ, 2'h1, 2'h0, 2'h0, 8'h00);
        chk(st[15:8], 8'hC3);
        op(OP_ENTER, 2'h0, 2'h1, 2'h0, 8'h00);
        chk(st[2:0], 3'b110);
        apb(1'b0, CMD_OFS, 32'h0);
        chk(rd, 32'h00000101);
        // Reset in mid-run brings defaults back
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        op(OP_ENTER, 2'h0, 2'h0, 2'h3, 8'h00);
        chk(st[2:0], 3'b100);
        op(OP_ENTER, 2'h0, 2'h0, 2'h0, 8'h00);
        op(OP_READ, 2'h2, 2'h0, 2'h0, 8'h00);
        chk(st[15:8], 8'h0F);
        op(OP_EXIT, 2'h0, 2'h0, 2'h0, 8'h00);
        chk(viol, 8'h00);
        end_sim;
    end
endmodule : tb
